/* core/gas_pkg.sv */
// Package for the port function-select and output bit-clear block.
// Assumes a byte-addressed register port with 32-bit data words.
package gas_pkg;

	// Port geometry
	localparam int unsigned PIN_COUNT = 16;
	localparam int unsigned FIELD_W = 4;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] OFS_IN_DATA = 8'h10;
	localparam logic [7:0] OFS_OUT_DATA = 8'h14;
	localparam logic [7:0] OFS_SET_RESET = 8'h18;
	localparam logic [7:0] OFS_LOCK = 8'h1c;
	localparam logic [7:0] OFS_SEL_LOW = 8'h20;
	localparam logic [7:0] OFS_SEL_HIGH = 8'h24;
	localparam logic [7:0] OFS_BIT_CLEAR = 8'h28;

	// Field positions
	localparam int unsigned SET_LSB = 0;
	localparam int unsigned CLEAR_LSB = 16;
	localparam int unsigned LOCK_KEY_BIT = 16;

	// Reset values
	localparam logic [31:0] SEL_LOW_RST = 32'h0000_0000;
	localparam logic [31:0] SEL_HIGH_RST = 32'h0000_0000;
	localparam logic [15:0] OUT_DATA_RST = 16'h0000;
	localparam logic [3:0] ALT_FUNC_ZERO = 4'h0;

	// Lock key write sequence: 1, 0, 1 with the same lock bits
	typedef enum logic [1:0] {
		LK_IDLE = 2'b00,
		LK_ONE = 2'b01,
		LK_ZERO = 2'b10,
		LK_DONE = 2'b11
	} gas_lock_state_type;

endpackage

/* core/gas_lock_seq.sv */
// Lock key sequencer: tracks the key write sequence and holds lock bits.
// Assumes wr_stb_i is a one-cycle write strobe to the lock register.
`timescale 1ns/1ps
module gas_lock_seq (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Lock register write
	input wire logic wr_stb_i,
	input wire logic [16:0] wr_data_i,
	// Lock state
	output logic lock_key_o,
	output logic [15:0] lock_bits_o
);

	typedef struct packed {
		gas_pkg::gas_lock_state_type st;
		logic key;
		logic [15:0] bits;
	} gas_lock_regs_type;

	gas_lock_regs_type q;
	gas_lock_regs_type d;
	logic same;

	// Sequence step; lock bits frozen once the key is active
	always_comb begin
		d = q;
		same = (wr_data_i[15:0] == q.bits);
		if (wr_stb_i) begin
			if (!q.key) begin
				d.bits = wr_data_i[15:0];
			end
			case (q.st)
				gas_pkg::LK_IDLE: begin
					d.st = wr_data_i[16] ? gas_pkg::LK_ONE : gas_pkg::LK_IDLE;
				end
				gas_pkg::LK_ONE: begin
					if (!wr_data_i[16] && same) begin
						d.st = gas_pkg::LK_ZERO;
					end else begin
						d.st = wr_data_i[16] ? gas_pkg::LK_ONE : gas_pkg::LK_IDLE;
					end
				end
				gas_pkg::LK_ZERO: begin
					if (wr_data_i[16] && same) begin
						d.st = gas_pkg::LK_DONE;
						d.key = 1'b1;
					end else begin
						d.st = gas_pkg::LK_IDLE;
					end
				end
				gas_pkg::LK_DONE: begin
					d.st = gas_pkg::LK_DONE;
				end
				default: begin
					d.st = gas_pkg::LK_IDLE;
				end
			endcase
		end
	end

	// Only a system reset releases the key
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign lock_key_o = q.key;
	assign lock_bits_o = q.bits;

endmodule // gas_lock_seq

/* core/gas_func_bank.sv */
// Bank of 4-bit alternate function selectors, one per pin.
// Assumes freeze_i already combines lock key and per-pin lock bits.
`timescale 1ns/1ps
module gas_func_bank (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Selector writes
	input wire logic we_low_i,
	input wire logic we_high_i,
	input wire logic [31:0] wr_data_i,
	input wire logic [15:0] freeze_i,
	// Selector fields, pin 0 in the low nibble
	output logic [63:0] sel_o
);

	typedef struct packed {
		logic [63:0] sel;
	} gas_bank_regs_type;

	gas_bank_regs_type q;
	gas_bank_regs_type d;
	logic [63:0] nxt;

	// One field per pin; a frozen field ignores writes
	for (genvar p = 0; p < 16; p++) begin : g_pin
		logic we;
		assign we = (p < 8) ? we_low_i : we_high_i;
		assign nxt[p*4 +: 4] = (we && !freeze_i[p]) ? wr_data_i[(p%8)*4 +: 4]
			: q.sel[p*4 +: 4];
	end

	always_comb begin
		d = q;
		d.sel = nxt;
	end

	// All pins come up on function zero
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			q.sel <= {gas_pkg::SEL_HIGH_RST, gas_pkg::SEL_LOW_RST};
		end else begin
			q <= d;
		end
	end

	assign sel_o = q.sel;

endmodule // gas_func_bank

/* core/gas_port.sv */
// Top of the port block: register port, output data, selectors, lock.
// Assumes a master that issues one-cycle strobes and never both at once;
// read data appear in the cycle after the read strobe and only there.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module gas_port (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_stb_i,
	input wire logic rd_stb_i,
	output logic [31:0] rd_data_o,
	// Pins
	input wire logic [15:0] pin_in_i,
	output logic [15:0] out_data_o,
	// Alternate function routing
	output logic [63:0] func_sel_o,
	output logic lock_key_o
);

	typedef struct packed {
		logic [15:0] out_data;
		logic [15:0] in_meta;
		logic [15:0] in_sync;
		logic [31:0] rd_data;
	} gas_port_regs_type;

	gas_port_regs_type q;
	gas_port_regs_type d;

	logic wr_out;
	logic wr_set_reset;
	logic wr_lock;
	logic wr_low;
	logic wr_high;
	logic wr_clear;
	logic [15:0] lock_bits;
	logic [15:0] freeze;
	logic [63:0] sel;

	// Write decode
	assign wr_out = wr_stb_i && (addr_i == gas_pkg::OFS_OUT_DATA);
	assign wr_set_reset = wr_stb_i && (addr_i == gas_pkg::OFS_SET_RESET);
	assign wr_lock = wr_stb_i && (addr_i == gas_pkg::OFS_LOCK);
	assign wr_low = wr_stb_i && (addr_i == gas_pkg::OFS_SEL_LOW);
	assign wr_high = wr_stb_i && (addr_i == gas_pkg::OFS_SEL_HIGH);
	assign wr_clear = wr_stb_i && (addr_i == gas_pkg::OFS_BIT_CLEAR);

	// Lock bits only bite once the key is active
	assign freeze = lock_key_o ? lock_bits : 16'h0000;

	// Lock key sequencer
	gas_lock_seq u_lock (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.wr_stb_i(wr_lock),
		.wr_data_i(wr_data_i[16:0]),
		.lock_key_o(lock_key_o),
		.lock_bits_o(lock_bits)
	);

	// Per-pin function selectors
	gas_func_bank u_bank (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.we_low_i(wr_low),
		.we_high_i(wr_high),
		.wr_data_i(wr_data_i),
		.freeze_i(freeze),
		.sel_o(sel)
	);

	// Output data, input sampling and read mux
	always_comb begin
		d = q;
		// Pins are asynchronous; two stages before any use
		d.in_meta = pin_in_i;
		d.in_sync = q.in_meta;
		// Output data updates
		if (wr_out) begin
			d.out_data = wr_data_i[15:0];
		end
		if (wr_set_reset) begin
			// Clear first, then set, so set has priority
			d.out_data = (q.out_data & ~wr_data_i[gas_pkg::CLEAR_LSB +: 16])
				| wr_data_i[gas_pkg::SET_LSB +: 16];
		end
		if (wr_clear) begin
			d.out_data = q.out_data & ~wr_data_i[15:0];
		end
		// Read data stand one cycle only
		d.rd_data = 32'h0000_0000;
		if (rd_stb_i) begin
			case (addr_i)
				gas_pkg::OFS_IN_DATA: begin
					d.rd_data = {16'h0000, q.in_sync};
				end
				gas_pkg::OFS_OUT_DATA: begin
					d.rd_data = {16'h0000, q.out_data};
				end
				gas_pkg::OFS_SET_RESET: begin
					d.rd_data = 32'h0000_0000;
				end
				gas_pkg::OFS_LOCK: begin
					d.rd_data = {15'h0000, lock_key_o, lock_bits};
				end
				gas_pkg::OFS_SEL_LOW: begin
					d.rd_data = sel[31:0];
				end
				gas_pkg::OFS_SEL_HIGH: begin
					d.rd_data = sel[63:32];
				end
				gas_pkg::OFS_BIT_CLEAR: begin
					d.rd_data = 32'h0000_0000;
				end
				default: begin
					d.rd_data = 32'h0000_0000;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			q.out_data <= gas_pkg::OUT_DATA_RST;
			q.in_meta <= 16'h0000;
			q.in_sync <= 16'h0000;
			q.rd_data <= 32'h0000_0000;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from flops
	assign rd_data_o = q.rd_data;
	assign out_data_o = q.out_data;
	assign func_sel_o = sel;

	// Low selectors are zero right after reset
	low_reset_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		$fell(sys_rst_i) |-> func_sel_o[31:0] == gas_pkg::SEL_LOW_RST)
		else $error("low selector not zero after reset");

	// High selectors are zero right after reset
	high_reset_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		$fell(sys_rst_i) |-> func_sel_o[63:32] == gas_pkg::SEL_HIGH_RST)
		else $error("high selector not zero after reset");

	// An unlocked low write lands in all eight fields
	low_write_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(wr_low && freeze[7:0] == 8'h00) |=> func_sel_o[31:0] == $past(wr_data_i))
		else $error("low selector write lost");

	// An unlocked high write lands with pin 8 lowest
	high_write_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(wr_high && freeze[15:8] == 8'h00) |=> func_sel_o[35:32] == $past(wr_data_i[3:0])
		&& func_sel_o[63:32] == $past(wr_data_i))
		else $error("high selector write lost");

	// Low selector read returns the routed fields of pins 0 to 7
	sel_readback_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(rd_stb_i && addr_i == gas_pkg::OFS_SEL_LOW) |=> rd_data_o == $past(func_sel_o[31:0]))
		else $error("selector readback mismatch");

	// Bit-clear write drops exactly the bits written one
	clear_bits_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wr_clear |=> out_data_o == ($past(out_data_o) & ~$past(wr_data_i[15:0])))
		else $error("bit clear result wrong");

	// Bit-clear register reads as zero
	clear_read_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(rd_stb_i && addr_i == gas_pkg::OFS_BIT_CLEAR) |=> rd_data_o == 32'h0000_0000)
		else $error("bit clear read not zero");

	// Locked pin 0 field holds through any write
	lock_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(lock_key_o && lock_bits[0]) |=> func_sel_o[3:0] == $past(func_sel_o[3:0]))
		else $error("locked selector changed");

	// Lock key, once on, stays on for two further cycles
	lock_sticky_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		$rose(lock_key_o) |=> lock_key_o [*2])
		else $error("lock key dropped");

	// Set beats clear on the same bit
	set_prio_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wr_set_reset |=> out_data_o == (($past(out_data_o)
		& ~$past(wr_data_i[31:16])) | $past(wr_data_i[15:0])))
		else $error("set did not win over clear");

	// Per-pin selector checks; each field is tied to its own lock bit,
	// so a lock on one pin must never leak into its neighbours.
	for (genvar p = 0; p < 16; p++) begin : g_pin_chk
		// An unlocked field takes its own nibble of the written word
		pin_write_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
			(((p < 8) ? wr_low : wr_high) && !freeze[p])
			|=> func_sel_o[p*4 +: 4] == $past(wr_data_i[(p%8)*4 +: 4]))
			else $error("pin selector write lost");

		// A frozen field keeps its code whatever is written
		pin_frozen_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
			freeze[p]
			|=> func_sel_o[p*4 +: 4] == $past(func_sel_o[p*4 +: 4]))
			else $error("frozen selector changed");
	end

	// Selectors move only on a selector write
	sel_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!(wr_low || wr_high)
		|=> $stable(func_sel_o))
		else $error("selector changed without write");

	// Output data move only on the three writes that own them
	out_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!(wr_out || wr_set_reset || wr_clear)
		|=> $stable(out_data_o))
		else $error("output data changed without write");

	// Reset clears the key, the output data and the read data
	reset_state_a: assert property (@(posedge clock_i) sys_rst_i
		|=> (!lock_key_o && out_data_o == gas_pkg::OUT_DATA_RST
		&& rd_data_o == 32'h0000_0000))
		else $error("reset state wrong");

	// Reset puts every pin back on function zero
	sel_reset_a: assert property (@(posedge clock_i) sys_rst_i
		|=> func_sel_o == {gas_pkg::SEL_HIGH_RST, gas_pkg::SEL_LOW_RST})
		else $error("selectors not cleared by reset");

	// Only a reset may drop the key; software has no way back
	key_no_drop_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!$fell(lock_key_o))
		else $error("lock key fell without reset");

	// The key rises only right after a lock register write
	key_needs_write_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		$rose(lock_key_o)
		|-> $past(wr_lock))
		else $error("lock key rose without write");

	// Lock bits are frozen together with the key
	lock_bits_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		lock_key_o
		|=> lock_bits == $past(lock_bits))
		else $error("lock bits changed under key");

	// Lock register reads back key and bits
	key_read_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(rd_stb_i && addr_i == gas_pkg::OFS_LOCK)
		|=> rd_data_o == {15'h0000, $past(lock_key_o), $past(lock_bits)})
		else $error("lock readback wrong");

	// Code zero written to pin 0 selects function zero
	af_zero_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(wr_low && !freeze[0] && wr_data_i[3:0] == gas_pkg::ALT_FUNC_ZERO)
		|=> func_sel_o[3:0] == gas_pkg::ALT_FUNC_ZERO)
		else $error("function zero not selected");

	// Every bit named in the set half ends up high
	set_high_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wr_set_reset
		|=> (out_data_o & $past(wr_data_i[15:0])) == $past(wr_data_i[15:0]))
		else $error("set bit not high");

	// Output data read shows the cleared bits
	out_read_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(rd_stb_i && addr_i == gas_pkg::OFS_OUT_DATA)
		|=> rd_data_o == {16'h0000, $past(out_data_o)})
		else $error("output data readback wrong");

	// Read data stand one cycle; an idle bus reads zero
	rd_idle_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!rd_stb_i
		|=> rd_data_o == 32'h0000_0000)
		else $error("read data not zero when idle");

	// The reserved upper half of a bit-clear write does nothing
	clear_upper_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(wr_clear && wr_data_i[15:0] == 16'h0000)
		|=> $stable(out_data_o))
		else $error("reserved clear bits acted");

	// High selector read returns pins 8 to 15
	high_readback_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(rd_stb_i && addr_i == gas_pkg::OFS_SEL_HIGH)
		|=> rd_data_o == $past(func_sel_o[63:32]))
		else $error("high selector readback mismatch");

endmodule // gas_port

/* testbench/test_gas_port.sv */
// Self-checking bench for the port block: selectors, output data, bit clear and lock.
// Assumes the register port contract: one-cycle strobes, read data one cycle later.
`timescale 1ns/1ps
module test_gas_port;
	// Design inputs and outputs
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wr_data_i = 32'h0000_0000;
	logic wr_stb_i = 1'b0;
	logic rd_stb_i = 1'b0;
	logic [15:0] pin_in_i = 16'h0000;
	logic [31:0] rd_data_o;
	logic [15:0] out_data_o;
	logic [63:0] func_sel_o;
	logic lock_key_o;
	// Bookkeeping and reference model
	int num_errors = 0;
	int tests_run = 0;
	int i;
	logic [31:0] seed = 32'h16d8;
	logic [63:0] m_sel;
	logic [15:0] m_od, m_lock, m_pin;
	logic m_key;
	logic [31:0] lk;

	// 125 MHz clock
	always #4 clock_i = ~clock_i;

	gas_port gas_port_inst (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.addr_i(addr_i),
		.wr_data_i(wr_data_i),
		.wr_stb_i(wr_stb_i),
		.rd_stb_i(rd_stb_i),
		.rd_data_o(rd_data_o),
		.pin_in_i(pin_in_i),
		.out_data_o(out_data_o),
		.func_sel_o(func_sel_o),
		.lock_key_o(lock_key_o)
	);

	// Fixed-seed xorshift so every run sees the same stimulus
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Expected readback; write-only and unmapped places read as zero
	function automatic logic [31:0] m_read(input logic [7:0] a);
		case (a)
			8'h10: return {16'h0000, m_pin};
			8'h14: return {16'h0000, m_od};
			8'h1c: return {15'h0000, m_key, m_lock};
			8'h20: return m_sel[31:0];
			8'h24: return m_sel[63:32];
			default: return 32'h0000_0000;
		endcase
	endfunction

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
			num_errors++;
		end
	endtask

	// Bus write plus model update; clear is applied before set so set wins
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_stb_i <= 1'b1;
		@(posedge clock_i);
		wr_stb_i <= 1'b0;
		#1;
		case (a)
			8'h14: m_od = d[15:0];
			8'h18: m_od = (m_od & ~d[31:16]) | d[15:0];
			8'h28: m_od = m_od & ~d[15:0];
			8'h1c: if (!m_key) m_lock = d[15:0];
			8'h20, 8'h24: begin
				for (int p = 0; p < 8; p++) begin
					if (!(m_key && m_lock[p + (a[2] ? 8 : 0)])) begin
						m_sel[(a[2] ? 32 : 0) + p * 4 +: 4] = d[p * 4 +: 4];
					end
				end
			end
			default: ;
		endcase
	endtask

	// Bus read; the data are sampled in the one cycle that they stand
	task automatic rd_chk(input logic [7:0] a);
		@(posedge clock_i);
		addr_i <= a;
		rd_stb_i <= 1'b1;
		@(posedge clock_i);
		rd_stb_i <= 1'b0;
		#1;
		check("rd_data_o", {32'h0, rd_data_o}, {32'h0, m_read(a)});
	endtask

	task automatic do_reset();
		sys_rst_i <= 1'b1;
		repeat (10) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		m_sel = 64'h0;
		m_od = 16'h0000;
		m_lock = 16'h0000;
		m_key = 1'b0;
		#1;
	endtask

	task automatic finish_test();
		if (num_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (5000) @(posedge clock_i);
		num_errors++;
		finish_test();
	end

	// Main sequence
	initial begin
		m_pin = 16'h0000;
		do_reset();
		check("func_sel_o", func_sel_o, 64'h0);
		rd_chk(8'h20);
		rd_chk(8'h24);
		rd_chk(8'h28);
		rd_chk(8'h2c);
		// Selector writes alternate between halves, then code zero
		for (i = 0; i < 6; i++) begin
			wr(i[0] ? 8'h24 : 8'h20, rnd());
			check("func_sel_o", func_sel_o, m_sel);
			rd_chk(8'h20);
			rd_chk(8'h24);
		end
		wr(8'h20, 32'h0000_0000);
		check("func_sel_o", func_sel_o, m_sel);
		// Bit clear against random output data, reserved half included
		for (i = 0; i < 6; i++) begin
			wr(8'h14, rnd());
			wr(8'h28, (i == 5) ? 32'hffff_0000 : rnd());
			check("out_data_o", {48'h0, out_data_o}, {48'h0, m_od});
			rd_chk(8'h28);
		end
		// Set and clear on overlapping bits
		wr(8'h14, 32'h0000_0f0f);
		wr(8'h18, 32'h00ff_0ff0);
		check("out_data_o", {48'h0, out_data_o}, {48'h0, m_od});
		rd_chk(8'h14);
		// Pin levels through the synchroniser
		lk = rnd();
		@(posedge clock_i);
		pin_in_i <= lk[15:0];
		m_pin = lk[15:0];
		repeat (2) @(posedge clock_i);
		rd_chk(8'h10);
		// Lock key sequence, then selector writes on a mix of locked pins
		lk = rnd() & 32'h0000_ffff;
		wr(8'h1c, lk | 32'h0001_0000);
		wr(8'h1c, lk);
		check("lock_key_o", {63'h0, lock_key_o}, 64'h0);
		rd_chk(8'h1c);
		wr(8'h1c, lk | 32'h0001_0000);
		m_lock = lk[15:0];
		m_key = 1'b1;
		check("lock_key_o", {63'h0, lock_key_o}, 64'h1);
		wr(8'h1c, ~lk & 32'h0000_ffff);
		rd_chk(8'h1c);
		for (i = 0; i < 4; i++) begin
			wr(i[0] ? 8'h24 : 8'h20, rnd());
			check("func_sel_o", func_sel_o, m_sel);
			rd_chk(8'h20);
			rd_chk(8'h24);
		end
		// Reset in mid-run releases the lock
		@(posedge clock_i);
		do_reset();
		check("func_sel_o", func_sel_o, 64'h0);
		check("lock_key_o", {63'h0, lock_key_o}, 64'h0);
		wr(8'h24, rnd());
		wr(8'h20, rnd());
		check("func_sel_o", func_sel_o, m_sel);
		finish_test();
	end
endmodule // test_gas_port
